// ==== core/ptc_params.svh ====
// register map, field positions and reset values for the port t clock-out and interrupt control slice
`ifndef PTC_PARAMS_SVH
`define PTC_PARAMS_SVH
`define PTC_OFF_PORT_T_DATA 12'h0240
`define PTC_OFF_PORT_T_DIR 12'h0242
`define PTC_OFF_PORT_T_INPUT 12'h0241
`define PTC_OFF_CLK_CTL 12'h0030
`define PTC_OFF_IRQ_CTL 12'h0034
`define PTC_OFF_RESERVED 12'h0038
`define PTC_OFF_IRQ_STATUS 12'h0040
`define PTC_OFF_IRQ_MASK 12'h0044
`define PTC_OFF_SVC 12'h0048
`define PTC_BIT_CLK_DISABLE 7
`define PTC_BIT_PREDIV 5
`define PTC_BIT_EDGE_SEL 7
`define PTC_BIT_IRQ_CONNECT 6
`define PTC_BIT_NMI_CONNECT 5
`define PTC_RST_CLK_CTL 8'h00
`define PTC_RST_IRQ_CTL 8'h40
`define PTC_RST_BYTE 8'h00
`define PTC_PREDIV_LAST 4'hf
`define PTC_RATE_MSB 4
`define PTC_STAT_COUNT 3
`define PTC_RESP_OKAY 2'b00
`define PTC_RESP_SLVERR 2'b10
`endif

// ==== core/ptc_pkg.sv ====
// shared types for the port t clock-out and interrupt control slice
package ptc_pkg;
  typedef logic [7:0] ptc_byte_type;
  typedef enum logic [1:0] {
    PTC_STAT_IRQ_EDGE,
    PTC_STAT_IRQ_LEVEL,
    PTC_STAT_NMI
  } ptc_event_type;
endpackage : ptc_pkg

// ==== core/ptc_port_t_clockout_irq_ctrl.sv ====
// port t data, free-running clock output and external interrupt pin control behind axi4-lite
`include "ptc_params.svh"
module ptc_port_t_clockout_irq_ctrl
  import ptc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic special_mode,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic ext_clock_out,
  input wire logic interrupt_pin_n,
  input wire logic nonmaskable_interrupt_pin_n,
  output logic irq_request,
  output logic nmi_request,
  output logic irq,
  input wire logic [7:0] port_t_pin_in,
  output logic [7:0] port_t_pin_out,
  output logic [7:0] port_t_pin_oe,
  input wire logic [7:0] segment_enable,
  input wire logic [7:0] segment_out,
  input wire logic [7:0] timer_enable,
  input wire logic [7:0] timer_out
);
  ////////////////////////////////////////////////////////////////////////////
  // registers and state
  ptc_byte_type port_t_data;
  ptc_byte_type port_t_direction;
  ptc_byte_type clock_output_control;
  ptc_byte_type external_interrupt_control;
  logic edge_written;
  logic nmi_written;
  logic [`PTC_STAT_COUNT-1:0] irq_status;
  logic [`PTC_STAT_COUNT-1:0] irq_mask;
  logic [7:0] pin_meta;
  logic [7:0] port_t_input;
  logic [1:0] irq_meta;
  logic [1:0] irq_sync;
  logic irq_prev;
  logic edge_pending;
  logic [4:0] rate_count;
  logic [3:0] prediv_count;
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic svc_write;
  logic edge_event;
  logic level_req;
  logic nmi_req;
  logic rate_tick;
  logic next_clk;
  ptc_byte_type eff_dir;
  ptc_byte_type next_pin_out;
  ptc_byte_type port_t_read;
  logic [31:0] next_rdata;
  logic next_rerr;
  logic status_write;
  logic [`PTC_STAT_COUNT-1:0] status_set;
  logic [`PTC_STAT_COUNT-1:0] status_clear;
  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign svc_write = do_write && aw_addr == `PTC_OFF_SVC && w_strb[0] && w_data[0];
  // address channel, ready low from acceptance until the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      s_axi_awready <= 1'b0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else begin
        s_axi_awready <= !aw_held && !s_axi_bvalid;
        if (do_write) begin
          aw_held <= 1'b0;
        end
      end
    end
  end
  // data channel, same discipline as the address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_wready <= 1'b0;
    end else if (clk_en) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else begin
        s_axi_wready <= !w_held && !s_axi_bvalid;
        if (do_write) begin
          w_held <= 1'b0;
        end
      end
    end
  end
  // response, offered once both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PTC_RESP_OKAY;
    end else if (clk_en) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          `PTC_OFF_PORT_T_DATA, `PTC_OFF_PORT_T_DIR, `PTC_OFF_PORT_T_INPUT, `PTC_OFF_CLK_CTL,
          `PTC_OFF_IRQ_CTL, `PTC_OFF_RESERVED, `PTC_OFF_IRQ_STATUS, `PTC_OFF_IRQ_MASK,
          `PTC_OFF_SVC: s_axi_bresp <= `PTC_RESP_OKAY;
          default: s_axi_bresp <= `PTC_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_t_data <= `PTC_RST_BYTE;
      port_t_direction <= `PTC_RST_BYTE;
      clock_output_control <= `PTC_RST_CLK_CTL;
      irq_mask <= '0;
    end else if (clk_en && do_write && w_strb[0]) begin
      if (aw_addr == `PTC_OFF_PORT_T_DATA) begin
        port_t_data <= w_data[7:0];
      end
      if (aw_addr == `PTC_OFF_PORT_T_DIR) begin
        port_t_direction <= w_data[7:0];
      end
      if (aw_addr == `PTC_OFF_CLK_CTL) begin
        clock_output_control <= w_data[7:0];
      end
      if (aw_addr == `PTC_OFF_IRQ_MASK) begin
        irq_mask <= w_data[`PTC_STAT_COUNT-1:0];
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      external_interrupt_control <= `PTC_RST_IRQ_CTL;
      edge_written <= 1'b0;
      nmi_written <= 1'b0;
    end else if (clk_en && do_write && w_strb[0] && aw_addr == `PTC_OFF_IRQ_CTL) begin
      external_interrupt_control[`PTC_BIT_IRQ_CONNECT] <= w_data[`PTC_BIT_IRQ_CONNECT];
      if (special_mode || !edge_written) begin
        external_interrupt_control[`PTC_BIT_EDGE_SEL] <= w_data[`PTC_BIT_EDGE_SEL];
        edge_written <= 1'b1;
      end
      if (special_mode || !nmi_written) begin
        external_interrupt_control[`PTC_BIT_NMI_CONNECT] <= w_data[`PTC_BIT_NMI_CONNECT];
        nmi_written <= 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= '0;
      port_t_input <= '0;
      irq_meta <= 2'b11;
      irq_sync <= 2'b11;
      irq_prev <= 1'b1;
    end else if (clk_en) begin
      pin_meta <= port_t_pin_in;
      port_t_input <= pin_meta;
      irq_meta <= {nonmaskable_interrupt_pin_n, interrupt_pin_n};
      irq_sync <= irq_meta;
      irq_prev <= irq_sync[0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // external interrupt logic
  assign edge_event = external_interrupt_control[`PTC_BIT_EDGE_SEL] && irq_prev && !irq_sync[0];
  assign level_req = !external_interrupt_control[`PTC_BIT_EDGE_SEL] && !irq_sync[0];
  assign nmi_req = external_interrupt_control[`PTC_BIT_NMI_CONNECT] && !irq_sync[1];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_pending <= 1'b0;
    end else if (clk_en) begin
      if (edge_event) edge_pending <= 1'b1;
      else if (svc_write) edge_pending <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_request <= 1'b0;
      nmi_request <= 1'b0;
    end else if (clk_en) begin
      irq_request <= external_interrupt_control[`PTC_BIT_IRQ_CONNECT] && (edge_pending || level_req);
      nmi_request <= nmi_req;
    end
  end
  assign status_write = do_write && w_strb[0] && aw_addr == `PTC_OFF_IRQ_STATUS;
  assign status_set[PTC_STAT_IRQ_EDGE] = edge_event;
  assign status_set[PTC_STAT_IRQ_LEVEL] = level_req;
  assign status_set[PTC_STAT_NMI] = nmi_req;
  assign status_clear = status_write ? w_data[`PTC_STAT_COUNT-1:0] : '0;
  // one sticky bit per event, a new event beats a clear in the same cycle
  genvar si;
  generate
    for (si = 0; si < `PTC_STAT_COUNT; si++) begin : g_status
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          irq_status[si] <= 1'b0;
        end else if (clk_en) begin
          if (status_set[si]) begin
            irq_status[si] <= 1'b1;
          end else if (status_clear[si]) begin
            irq_status[si] <= 1'b0;
          end
        end
      end
    end
  endgenerate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(irq_status & irq_mask);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // clock output divider
  assign rate_tick = rate_count == clock_output_control[`PTC_RATE_MSB:0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_count <= '0;
    end else if (clk_en) begin
      rate_count <= rate_tick ? 5'h00 : rate_count + 5'h01;
    end
  end
  // the predivide stage advances once per divided period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prediv_count <= '0;
    end else if (clk_en && rate_tick) begin
      prediv_count <= prediv_count + 4'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_clock_out <= 1'b0;
    end else if (clk_en) begin
      ext_clock_out <= next_clk;
    end
  end
  always_comb begin
    next_clk = 1'b0;
    if (!clock_output_control[`PTC_BIT_CLK_DISABLE]) begin
      if (clock_output_control[`PTC_BIT_PREDIV]) next_clk = rate_tick && prediv_count == `PTC_PREDIV_LAST;
      else next_clk = rate_tick;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // port t pin muxing, one generate entry per pin
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      always_comb begin
        if (segment_enable[gi]) begin
          eff_dir[gi] = 1'b0;
          next_pin_out[gi] = segment_out[gi];
        end else if (timer_enable[gi]) begin
          eff_dir[gi] = 1'b1;
          next_pin_out[gi] = timer_out[gi];
        end else begin
          eff_dir[gi] = port_t_direction[gi];
          next_pin_out[gi] = port_t_data[gi];
        end
        port_t_read[gi] = port_t_direction[gi] ? port_t_data[gi] : port_t_input[gi];
      end
    end
  endgenerate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_t_pin_out <= '0;
      port_t_pin_oe <= '0;
    end else if (clk_en) begin
      port_t_pin_out <= next_pin_out;
      port_t_pin_oe <= eff_dir;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read path
  always_comb begin
    next_rdata = '0;
    next_rerr = 1'b0;
    case (s_axi_araddr)
      `PTC_OFF_PORT_T_DATA: next_rdata[7:0] = port_t_read;
      `PTC_OFF_PORT_T_INPUT: next_rdata[7:0] = port_t_input;
      `PTC_OFF_PORT_T_DIR: next_rdata[7:0] = port_t_direction;
      `PTC_OFF_CLK_CTL: next_rdata[7:0] = clock_output_control;
      `PTC_OFF_IRQ_CTL: next_rdata[7:0] = external_interrupt_control;
      `PTC_OFF_RESERVED, `PTC_OFF_SVC: next_rdata = '0;
      `PTC_OFF_IRQ_STATUS: next_rdata[2:0] = irq_status;
      `PTC_OFF_IRQ_MASK: next_rdata[2:0] = irq_mask;
      default: next_rerr = 1'b1;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
      end else begin
        s_axi_arready <= !s_axi_rvalid;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // read data and response are captured with the address and stand until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= '0;
      s_axi_rresp <= `PTC_RESP_OKAY;
    end else if (clk_en && s_axi_arvalid && s_axi_arready) begin
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rerr ? `PTC_RESP_SLVERR : `PTC_RESP_OKAY;
    end
  end
endmodule : ptc_port_t_clockout_irq_ctrl

// ==== verif/ptc_checker.sv ====
// port-level assertions for the port t slice
module ptc_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_clock_out,
  input wire logic irq,
  input wire logic [7:0] port_t_pin_out,
  input wire logic [7:0] port_t_pin_oe,
  input wire logic [7:0] segment_enable,
  input wire logic [7:0] timer_enable,
  input wire logic [7:0] timer_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] seg_q;
  logic [7:0] tim_q;
  logic [7:0] tout_q;
  logic en_q;
  logic [7:0] tsel;
  always_ff @(posedge aclk) begin
    seg_q <= segment_enable;
    tim_q <= timer_enable;
    tout_q <= timer_out;
    en_q <= clk_en;
  end
  assign tsel = tim_q & ~seg_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid repeated");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid repeated");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write ready early");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read ready early");
  AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000) else $error("upper data set");
  AST_SEG_OE: assert property (en_q |-> (port_t_pin_oe & seg_q) == 8'h00) else $error("segment pin driven");
  AST_TIM_DRIVE: assert property (en_q |-> (port_t_pin_oe & tsel) == tsel
    && (port_t_pin_out & tsel) == (tout_q & tsel)) else $error("timer pin wrong");
  cover property (irq);
  cover property ($rose(ext_clock_out));
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : ptc_checker
bind ptc_port_t_clockout_irq_ctrl ptc_checker ptc_checker_inst (.*);

// ==== verif/ptc_pin_model.sv ====
// board side of the port t pins and the two interrupt pins
module ptc_pin_model (
  input wire logic [7:0] port_t_pin_out,
  input wire logic [7:0] port_t_pin_oe,
  input wire logic [7:0] board_level,
  input wire logic irq_low,
  input wire logic nmi_low,
  output logic [7:0] port_t_pin_in,
  output logic interrupt_pin_n,
  output logic nonmaskable_interrupt_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // a driving design wins the wire, else the board level shows
  assign port_t_pin_in = (port_t_pin_out & port_t_pin_oe) | (board_level & ~port_t_pin_oe);
  // pulled-up lines, pulled low by board sources
  assign interrupt_pin_n = !irq_low;
  assign nonmaskable_interrupt_pin_n = !nmi_low;
endmodule : ptc_pin_model

// ==== verif/tb.sv ====
// self-checking bench for the port t slice
`include "ptc_params.svh"
module tb import ptc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = '0, aresetn = '0, clk_en = 1'h1, special_mode = '0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_arvalid = '0, s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic ext_clock_out, interrupt_pin_n, nonmaskable_interrupt_pin_n, irq_request, nmi_request, irq;
  logic [7:0] port_t_pin_in, port_t_pin_out, port_t_pin_oe, segment_out = '0, timer_out = '0;
  logic [7:0] segment_enable = '0, timer_enable = '0, board_level = 8'h3c;
  logic irq_low = '0, nmi_low = '0;
  int n_mismatch = 0, n_tests = 0;
  ptc_byte_type rd_v;
  ptc_port_t_clockout_irq_ctrl ptc_port_t_clockout_irq_ctrl_inst (.*);
  ptc_pin_model ptc_pin_model_inst (.*);
  initial forever #4 aclk = ~aclk;
  task automatic results;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk
  task automatic bound(input int n);
    if (n >= 64) begin
      chk("bus wait", 0, n);
      results();
    end
  endtask : bound
  task automatic wr(input logic [11:0] a, input ptc_byte_type d);
    int n;
    logic aw, w;
    n = 0;
    aw = 1'h1;
    w = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while ((aw || w) && n < 64) begin
      @(posedge aclk);
      n++;
      if (aw && s_axi_awready === 1'h1) begin
        aw = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready === 1'h1) begin
        w = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end
    do begin @(posedge aclk); n++; end while (s_axi_bvalid !== 1'h1 && n < 64);
    resp = s_axi_bresp;
    bound(n);
  endtask : wr
  task automatic rc(input logic [11:0] a, input ptc_byte_type e, input string nm);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin @(posedge aclk); n++; end while (s_axi_arready !== 1'h1 && n < 64);
    s_axi_arvalid <= 1'h0;
    do begin @(posedge aclk); n++; end while (s_axi_rvalid !== 1'h1 && n < 64);
    resp = s_axi_rresp;
    bound(n);
    chk(nm, e, s_axi_rdata[7:0]);
  endtask : rc
  ////////////////////////////////////////////////////////////////
  initial begin
    int c;
    ptc_byte_type ctl_t [6] = '{8'h03, 8'h1f, 8'h01, 8'h20, 8'h23, 8'h83};
    int cnt_t [6] = '{32, 4, 64, 8, 2, 0};
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rc(`PTC_OFF_CLK_CTL, `PTC_RST_CLK_CTL, "clk ctl");
    rc(`PTC_OFF_IRQ_CTL, `PTC_RST_IRQ_CTL, "irq ctl");
    rc(`PTC_OFF_PORT_T_DATA, 8'h3c, "data in");
    wr(`PTC_OFF_RESERVED, 8'hff);
    chk("reserved resp", `PTC_RESP_OKAY, resp);
    rc(`PTC_OFF_RESERVED, 8'h00, "reserved");
    rc(12'h100, 8'h00, "unmapped");
    chk("unmapped resp", `PTC_RESP_SLVERR, resp);
    wr(12'h100, 8'h00);
    chk("unmapped wr resp", `PTC_RESP_SLVERR, resp);
    $display("test reset done");
    wr(`PTC_OFF_IRQ_CTL, 8'hc0);
    wr(`PTC_OFF_IRQ_CTL, 8'h20);
    rc(`PTC_OFF_IRQ_CTL, 8'h80, "write once");
    irq_low <= 1'h1;
    nmi_low <= 1'h1;
    repeat (8) @(posedge aclk);
    chk("disconnected", 0, irq_request);
    chk("nmi disconnected", 0, nmi_request);
    irq_low <= 1'h0;
    nmi_low <= 1'h0;
    wr(`PTC_OFF_IRQ_CTL, 8'h40);
    wr(`PTC_OFF_SVC, 8'h01);
    wr(`PTC_OFF_IRQ_STATUS, 8'h07);
    wr(`PTC_OFF_IRQ_MASK, 8'h01);
    irq_low <= 1'h1;
    repeat (8) @(posedge aclk);
    irq_low <= 1'h0;
    repeat (8) @(posedge aclk);
    chk("edge latched", 1, irq_request);
    chk("irq raised", 1, irq);
    wr(`PTC_OFF_IRQ_MASK, 8'h00);
    repeat (2) @(posedge aclk);
    chk("irq masked", 0, irq);
    wr(`PTC_OFF_SVC, 8'h01);
    wr(`PTC_OFF_IRQ_STATUS, 8'h07);
    repeat (2) @(posedge aclk);
    chk("edge serviced", 0, irq_request);
    special_mode <= 1'h1;
    wr(`PTC_OFF_IRQ_CTL, 8'h60);
    rc(`PTC_OFF_IRQ_CTL, 8'h60, "special write");
    for (int i = 0; i < 2; i++) begin
      irq_low <= !i;
      nmi_low <= !i;
      repeat (8) @(posedge aclk);
      chk("level irq", !i, irq_request);
      chk("nmi", !i, nmi_request);
    end
    $display("test interrupt done");
    wr(`PTC_OFF_PORT_T_DIR, 8'hff);
    rc(`PTC_OFF_PORT_T_DATA, 8'h00, "data reset");
    wr(`PTC_OFF_PORT_T_DATA, 8'ha5);
    repeat (2) @(posedge aclk);
    chk("pin out", 8'ha5, port_t_pin_out);
    chk("pin oe", 8'hff, port_t_pin_oe);
    wr(`PTC_OFF_PORT_T_DIR, 8'h0f);
    repeat (2) @(posedge aclk);
    rc(`PTC_OFF_PORT_T_DATA, 8'h35, "data mixed");
    rc(`PTC_OFF_PORT_T_INPUT, 8'h35, "input");
    segment_enable <= 8'h81;
    timer_enable <= 8'h99;
    timer_out <= 8'h10;
    repeat (2) @(posedge aclk);
    chk("override oe", 8'h1e, port_t_pin_oe);
    chk("override out", 8'h14, port_t_pin_out & port_t_pin_oe);
    chk("segment out", 8'h00, port_t_pin_out & 8'h81);
    clk_en <= 1'h0;
    timer_out <= 8'h08;
    repeat (4) @(posedge aclk);
    chk("frozen out", 8'h14, port_t_pin_out & port_t_pin_oe);
    clk_en <= 1'h1;
    repeat (2) @(posedge aclk);
    chk("thawed out", 8'h0c, port_t_pin_out & port_t_pin_oe);
    $display("test port done");
    // rate 0 without predivide is never chosen at this bus rate
    for (int i = 0; i < 6; i++) begin
      wr(`PTC_OFF_CLK_CTL, ctl_t[i]);
      repeat (70) @(posedge aclk);
      c = 0;
      repeat (128) begin
        @(posedge aclk);
        if (ext_clock_out === 1'h1) c++;
      end
      chk("clock pulses", cnt_t[i], c);
    end
    $display("test clock done");
    results();
  end
endmodule : tb
